// >>> emspm_map.svh
`ifndef EMSPM_MAP_SVH
`define EMSPM_MAP_SVH

`define EMSPM_ADDR_W        4
`define EMSPM_DATA_W        16

`define EMSPM_GPS_OFS       4'h0
`define EMSPM_PUR_OFS       4'h1
`define EMSPM_PER_OFS       4'h2
`define EMSPM_DDR_OFS       4'h3
`define EMSPM_DR_OFS        4'h4
`define EMSPM_PIN_OFS       4'h5

`define EMSPM_PHB_BIT       1
`define EMSPM_IDX_BIT       2
`define EMSPM_PORT_MASK     16'h0006

`define EMSPM_GPS_RST       16'h0000
`define EMSPM_PUR_RST       16'h0006
`define EMSPM_PER_RST       16'h0000
`define EMSPM_DDR_RST       16'h0000
`define EMSPM_DR_RST        16'h0000

`define EMSPM_SYNC_STAGES   2

`endif

// >>> emspm_pkg.sv
`default_nettype none

package emspm_pkg;

    typedef enum logic [2:0] {
        EMSPM_DEC  = 3'b001,
        EMSPM_GPIO = 3'b010,
        EMSPM_SER  = 3'b100
    } emspm_mode_t;

    // the serial select outranks the gpio enable
    function automatic emspm_mode_t emspm_pin_mode(input logic alt, input logic gpio);
        if (alt) begin
            return EMSPM_SER;
        end else if (gpio) begin
            return EMSPM_GPIO;
        end
        return EMSPM_DEC;
    endfunction : emspm_pin_mode

endpackage : emspm_pkg

`default_nettype wire

// >>> emspm_pad_if.sv
`timescale 1ns/1ps
`default_nettype none

interface emspm_pad_if;
    logic drv_data;
    logic drv_en;
    logic launch;
    logic level;

    modport ctrl (output drv_data, output drv_en, output launch, input level);
    modport pad  (input drv_data, input drv_en, input launch, output level);
endinterface : emspm_pad_if

`default_nettype wire

// >>> emspm_pad.sv
`timescale 1ns/1ps
`default_nettype none

module emspm_pad (
    input  wire logic   clk,
    input  wire logic   rst,
    emspm_pad_if.pad    ctl,
    input  wire logic   pin_i,
    output logic        pin_o,
    output logic        pin_oe_n
);
    logic sync1_r;
    logic sync2_r;
    logic out_r;
    logic out_nxt;
    logic oe_n_r;
    logic oe_n_nxt;

    // data moves only on launch so the edge stays half a serial clock ahead
    // of sampling; the enable follows every cycle so release is prompt
    always_comb begin
        out_nxt  = ctl.launch ? ctl.drv_data : out_r;
        oe_n_nxt = ~ctl.drv_en;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            out_r   <= 1'b0;
            oe_n_r  <= 1'b1;
        end else begin
            sync1_r <= pin_i;
            sync2_r <= sync1_r;
            out_r   <= out_nxt;
            oe_n_r  <= oe_n_nxt;
        end
    end

    assign ctl.level = sync2_r;
    assign pin_o     = out_r;
    assign pin_oe_n  = oe_n_r;

endmodule : emspm_pad

`default_nettype wire

// >>> emspm_pin_mux.sv
// Overview of operation
// - phase-B alt select set puts serial master-out data on the phase-B pin.
// - select_a select set puts serial master-in data on the index pin.
// - after reset the phase-B pin feeds the decoder phase-B input.
// - after reset the index pin feeds the decoder index input.
// - clearing pull-up bit 1 turns off the phase-B pin pull-up.
// - clearing pull-up bit 2 turns off the index pin pull-up.
// - master-out data changes half a serial clock before slave sampling.
// - slave-out data changes half a serial clock before master sampling.
// - as slave, the slave-out pin floats whenever the slave is unselected.
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "emspm_map.svh"

module emspm_pin_mux #(
    parameter bit FULL_FEATURED = 1'b1
) (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic [`EMSPM_ADDR_W-1:0]     reg_addr,
    input  wire logic [`EMSPM_DATA_W-1:0]     reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [`EMSPM_DATA_W-1:0]     reg_rdata,
    input  wire logic                         phase_b_pin_i,
    output logic                              phase_b_pin_o,
    output logic                              phase_b_pin_oe_n,
    input  wire logic                         index_pin_i,
    output logic                              index_pin_o,
    output logic                              index_pin_oe_n,
    output logic      [1:0]                   pullup_en,
    output logic                              decoder1_phase_b_in,
    output logic                              decoder1_index_in,
    output logic                              timer_b_channel_one_in,
    output logic                              timer_b_channel_two_in,
    input  wire logic                         timer_b_channel_one_out,
    input  wire logic                         timer_b_channel_one_oe,
    input  wire logic                         timer_b_channel_two_out,
    input  wire logic                         timer_b_channel_two_oe,
    input  wire logic                         serial1_master_mode,
    input  wire logic                         serial1_slave_select_n,
    input  wire logic                         serial1_launch,
    input  wire logic                         serial1_master_out,
    input  wire logic                         serial1_slave_out,
    output logic                              serial1_master_out_rx,
    output logic                              serial1_master_in
);
    import emspm_pkg::*;

    logic [`EMSPM_DATA_W-1:0] gps_r;
    logic [`EMSPM_DATA_W-1:0] gps_nxt;
    logic [`EMSPM_DATA_W-1:0] pur_r;
    logic [`EMSPM_DATA_W-1:0] pur_nxt;
    logic [`EMSPM_DATA_W-1:0] per_r;
    logic [`EMSPM_DATA_W-1:0] per_nxt;
    logic [`EMSPM_DATA_W-1:0] ddr_r;
    logic [`EMSPM_DATA_W-1:0] ddr_nxt;
    logic [`EMSPM_DATA_W-1:0] dr_r;
    logic [`EMSPM_DATA_W-1:0] dr_nxt;
    logic [`EMSPM_DATA_W-1:0] rdata_r;
    logic [`EMSPM_DATA_W-1:0] rdata_nxt;
    logic [`EMSPM_DATA_W-1:0] pin_lvl;
    logic                     phase_b_alt_select;
    logic                     select_a;
    emspm_mode_t              mode_b;
    emspm_mode_t              mode_i;

    emspm_pad_if pb_if ();
    emspm_pad_if ix_if ();

    assign phase_b_alt_select = gps_r[`EMSPM_PHB_BIT];
    assign select_a           = gps_r[`EMSPM_IDX_BIT];

    // register file: only port bits 1 and 2 exist, the rest read zero
    always_comb begin
        gps_nxt   = gps_r;
        pur_nxt   = pur_r;
        per_nxt   = per_r;
        ddr_nxt   = ddr_r;
        dr_nxt    = dr_r;
        rdata_nxt = '0;
        if (reg_wr) begin
            unique case (reg_addr)
                `EMSPM_GPS_OFS: gps_nxt = reg_wdata & `EMSPM_PORT_MASK;
                `EMSPM_PUR_OFS: pur_nxt = reg_wdata & `EMSPM_PORT_MASK;
                `EMSPM_PER_OFS: per_nxt = reg_wdata & `EMSPM_PORT_MASK;
                `EMSPM_DDR_OFS: ddr_nxt = reg_wdata & `EMSPM_PORT_MASK;
                `EMSPM_DR_OFS:  dr_nxt  = reg_wdata & `EMSPM_PORT_MASK;
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `EMSPM_GPS_OFS: rdata_nxt = gps_r;
                `EMSPM_PUR_OFS: rdata_nxt = pur_r;
                `EMSPM_PER_OFS: rdata_nxt = per_r;
                `EMSPM_DDR_OFS: rdata_nxt = ddr_r;
                `EMSPM_DR_OFS:  rdata_nxt = dr_r;
                `EMSPM_PIN_OFS: rdata_nxt = pin_lvl;
                default:        rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gps_r   <= `EMSPM_GPS_RST;
            pur_r   <= `EMSPM_PUR_RST;
            per_r   <= `EMSPM_PER_RST;
            ddr_r   <= `EMSPM_DDR_RST;
            dr_r    <= `EMSPM_DR_RST;
            rdata_r <= '0;
        end else begin
            gps_r   <= gps_nxt;
            pur_r   <= pur_nxt;
            per_r   <= per_nxt;
            ddr_r   <= ddr_nxt;
            dr_r    <= dr_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    always_comb begin
        pin_lvl                 = '0;
        pin_lvl[`EMSPM_PHB_BIT] = pb_if.level;
        pin_lvl[`EMSPM_IDX_BIT] = ix_if.level;
    end

    assign pullup_en[0] = pur_r[`EMSPM_PHB_BIT];
    assign pullup_en[1] = pur_r[`EMSPM_IDX_BIT];

    assign mode_b = emspm_pin_mode(phase_b_alt_select, per_r[`EMSPM_PHB_BIT]);
    assign mode_i = emspm_pin_mode(select_a, per_r[`EMSPM_IDX_BIT]);

    // phase-B pin drivers
    always_comb begin
        pb_if.drv_data = 1'b0;
        pb_if.drv_en   = 1'b0;
        pb_if.launch   = 1'b1;
        unique case (mode_b)
            EMSPM_SER: begin
                pb_if.drv_data = serial1_master_out;
                pb_if.drv_en   = serial1_master_mode;
                pb_if.launch   = serial1_launch;
            end
            EMSPM_GPIO: begin
                pb_if.drv_data = dr_r[`EMSPM_PHB_BIT];
                pb_if.drv_en   = ddr_r[`EMSPM_PHB_BIT];
            end
            EMSPM_DEC: begin
                pb_if.drv_data = timer_b_channel_one_out;
                pb_if.drv_en   = timer_b_channel_one_oe;
            end
        endcase
    end

    // index pin drivers; an unselected slave lets the line float
    always_comb begin
        ix_if.drv_data = 1'b0;
        ix_if.drv_en   = 1'b0;
        ix_if.launch   = 1'b1;
        unique case (mode_i)
            EMSPM_SER: begin
                ix_if.drv_data = serial1_slave_out;
                ix_if.drv_en   = !serial1_master_mode && !serial1_slave_select_n;
                ix_if.launch   = serial1_launch;
            end
            EMSPM_GPIO: begin
                ix_if.drv_data = dr_r[`EMSPM_IDX_BIT];
                ix_if.drv_en   = ddr_r[`EMSPM_IDX_BIT];
            end
            EMSPM_DEC: begin
                ix_if.drv_data = timer_b_channel_two_out;
                ix_if.drv_en   = timer_b_channel_two_oe;
            end
        endcase
    end

    // a reduced variant offers no decoder, so its inputs stay low
    always_comb begin
        decoder1_phase_b_in    = 1'b0;
        decoder1_index_in      = 1'b0;
        timer_b_channel_one_in = 1'b0;
        timer_b_channel_two_in = 1'b0;
        serial1_master_out_rx  = 1'b0;
        serial1_master_in      = 1'b0;
        if (mode_b == EMSPM_DEC) begin
            decoder1_phase_b_in    = FULL_FEATURED && pb_if.level;
            timer_b_channel_one_in = pb_if.level;
        end
        if (mode_i == EMSPM_DEC) begin
            decoder1_index_in      = FULL_FEATURED && ix_if.level;
            timer_b_channel_two_in = ix_if.level;
        end
        if (mode_b == EMSPM_SER) begin
            serial1_master_out_rx = pb_if.level;
        end
        if (mode_i == EMSPM_SER) begin
            serial1_master_in = ix_if.level;
        end
    end

    emspm_pad u_pad_phase_b (
        .clk      (clk),
        .rst      (rst),
        .ctl      (pb_if.pad),
        .pin_i    (phase_b_pin_i),
        .pin_o    (phase_b_pin_o),
        .pin_oe_n (phase_b_pin_oe_n)
    );

    emspm_pad u_pad_index (
        .clk      (clk),
        .rst      (rst),
        .ctl      (ix_if.pad),
        .pin_i    (index_pin_i),
        .pin_o    (index_pin_o),
        .pin_oe_n (index_pin_oe_n)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_MOSI_LAUNCH: assert property (
        phase_b_alt_select && serial1_master_mode && serial1_launch
        |=> !phase_b_pin_oe_n && phase_b_pin_o == $past(serial1_master_out))
        else $error("master-out data not launched on phase-B pin");

    AST_MOSI_HOLD: assert property (
        phase_b_alt_select && !serial1_launch |=> $stable(phase_b_pin_o))
        else $error("master-out data moved outside a launch");

    AST_MISO_RX: assert property (
        select_a && serial1_master_mode |-> serial1_master_in == ix_if.level
        && !decoder1_index_in)
        else $error("index pin not routed to serial master-in");

    AST_MISO_LAUNCH: assert property (
        select_a && !serial1_master_mode && !serial1_slave_select_n && serial1_launch
        |=> !index_pin_oe_n && index_pin_o == $past(serial1_slave_out))
        else $error("slave-out data not launched on index pin");

    AST_MISO_FLOAT: assert property (
        select_a && !serial1_master_mode && serial1_slave_select_n |=> index_pin_oe_n)
        else $error("unselected slave drives the index pin");

    AST_DEC_B: assert property (
        !phase_b_alt_select && !per_r[`EMSPM_PHB_BIT]
        |-> decoder1_phase_b_in == (FULL_FEATURED && pb_if.level))
        else $error("phase-B pin not routed to decoder");

    AST_DEC_I: assert property (
        !select_a && !per_r[`EMSPM_IDX_BIT]
        |-> decoder1_index_in == (FULL_FEATURED && ix_if.level))
        else $error("index pin not routed to decoder");

    // judged from the write itself so a broken register path is caught too
    AST_PULLUP_B: assert property (
        reg_wr && reg_addr == `EMSPM_PUR_OFS && !reg_wdata[`EMSPM_PHB_BIT]
        |=> !pullup_en[0])
        else $error("phase-B pull-up stays on after its bit is cleared");

    AST_PULLUP_I: assert property (
        reg_wr && reg_addr == `EMSPM_PUR_OFS && !reg_wdata[`EMSPM_IDX_BIT]
        |=> !pullup_en[1])
        else $error("index pull-up stays on after its bit is cleared");

    AST_TIMER: assert property (
        mode_b == EMSPM_DEC && !timer_b_channel_one_oe |=> phase_b_pin_oe_n)
        else $error("timer drives phase-B pin while disabled");

    AST_TIMER_IN_B: assert property (
        mode_b == EMSPM_DEC |-> timer_b_channel_one_in == pb_if.level)
        else $error("phase-B pin not routed to timer channel one");

    AST_TIMER_IN_I: assert property (
        mode_i == EMSPM_DEC |-> timer_b_channel_two_in == ix_if.level)
        else $error("index pin not routed to timer channel two");

    AST_GPIO_NO_DEC: assert property (
        mode_b == EMSPM_GPIO |-> !decoder1_phase_b_in && !timer_b_channel_one_in)
        else $error("gpio phase-B pin still feeds decoder or timer");

    AST_SER_OVER_GPIO: assert property (
        phase_b_alt_select && per_r[`EMSPM_PHB_BIT] |-> mode_b == EMSPM_SER)
        else $error("gpio enable overrides the phase-B serial select");

    AST_SLAVE_NO_B: assert property (
        phase_b_alt_select && !serial1_master_mode |=> phase_b_pin_oe_n)
        else $error("slave drives the phase-B pin");

    AST_MASTER_NO_IX: assert property (
        select_a && serial1_master_mode |=> index_pin_oe_n)
        else $error("master drives the index pin");

    COV_SER_MASTER: cover property (phase_b_alt_select && serial1_master_mode
        && serial1_launch);
    COV_SER_SLAVE: cover property (select_a && !serial1_master_mode
        && !serial1_slave_select_n ##1 serial1_slave_select_n);
    COV_GPIO_OUT: cover property (mode_i == EMSPM_GPIO && !index_pin_oe_n);
    COV_TIMER: cover property (mode_b == EMSPM_DEC && !phase_b_pin_oe_n);
    COV_SER_OVER_GPIO: cover property (phase_b_alt_select && per_r[`EMSPM_PHB_BIT]);

endmodule : emspm_pin_mux

`default_nettype wire

// >>> emspm_pins_model.sv
`timescale 1ns/1ps
`default_nettype none

module emspm_pins_model (
    input  wire logic       clk,
    input  wire logic [1:0] drv_en_n,
    input  wire logic [1:0] drv_val,
    input  wire logic [1:0] pull_en,
    input  wire logic [1:0] ext_en,
    input  wire logic [1:0] ext_val,
    output logic      [1:0] level
);
    logic [1:0] float_r = 2'b01;

    // an undriven line with no pull-up wanders, so a stale level never passes for a drive
    always @(posedge clk) begin
        float_r <= ~float_r;
    end

    always_comb begin
        for (int k = 0; k < 2; k++) begin
            if (!drv_en_n[k]) begin
                level[k] = drv_val[k];
            end else if (ext_en[k]) begin
                level[k] = ext_val[k];
            end else if (pull_en[k]) begin
                level[k] = 1'b1;
            end else begin
                level[k] = float_r[k];
            end
        end
    end
endmodule : emspm_pins_model

`default_nettype wire

// >>> tb_encoder_spi_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
`include "emspm_map.svh"

module tb_encoder_spi_pin_mux;
    logic                     clk = 1'b0;
    logic                     rst = 1'b1;
    logic [`EMSPM_ADDR_W-1:0] reg_addr;
    logic [`EMSPM_DATA_W-1:0] reg_wdata;
    logic [`EMSPM_DATA_W-1:0] reg_rdata;
    logic                     reg_wr, reg_rd;
    logic [1:0]               pin_o, oe_n, pullup_en, ext_en, ext_val, level;
    logic                     dec_b, dec_i, tm1_in, tm2_in, t1o, t1e, t2o, t2e;
    logic                     ms, ss_n, launch, mo, so, mo_rx, mi;
    int                       errors = 0;
    int                       num_checks = 0;

    always #2 clk = ~clk;

    emspm_pin_mux dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .phase_b_pin_i(level[0]), .phase_b_pin_o(pin_o[0]), .phase_b_pin_oe_n(oe_n[0]),
        .index_pin_i(level[1]), .index_pin_o(pin_o[1]), .index_pin_oe_n(oe_n[1]),
        .pullup_en(pullup_en), .decoder1_phase_b_in(dec_b), .decoder1_index_in(dec_i),
        .timer_b_channel_one_in(tm1_in), .timer_b_channel_two_in(tm2_in),
        .timer_b_channel_one_out(t1o), .timer_b_channel_one_oe(t1e),
        .timer_b_channel_two_out(t2o), .timer_b_channel_two_oe(t2e),
        .serial1_master_mode(ms), .serial1_slave_select_n(ss_n), .serial1_launch(launch),
        .serial1_master_out(mo), .serial1_slave_out(so),
        .serial1_master_out_rx(mo_rx), .serial1_master_in(mi));

    emspm_pins_model far_u (.clk(clk), .drv_en_n(oe_n), .drv_val(pin_o), .pull_en(pullup_en),
        .ext_en(ext_en), .ext_val(ext_val), .level(level));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    endtask : rd

    // pin inputs pass two sync flops, so a third edge is enough
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    task automatic t_reset();
        rd(`EMSPM_GPS_OFS, 16'h0000, "select reg");
        rd(`EMSPM_PUR_OFS, 16'h0006, "pullup reg");
        rd(4'hf, 16'h0000, "unmapped");
        chk("oe_n idle", 16'h0003, {14'h0000, oe_n});
        @(posedge clk);
        ext_en  <= 2'b11;
        ext_val <= 2'b00;
        settle();
        chk("dec b low", 16'h0000, dec_b);
        chk("dec i low", 16'h0000, dec_i);
        @(posedge clk);
        ext_en <= 2'b00;
        settle();
        chk("dec b high", 16'h0001, dec_b);
        chk("dec i high", 16'h0001, dec_i);
        chk("tmr1 in", 16'h0001, tm1_in);
        rd(`EMSPM_PIN_OFS, 16'h0006, "pin levels");
        $display("test reset done");
    endtask : t_reset

    task automatic t_pullup();
        wr(`EMSPM_PUR_OFS, 16'hfffc);
        chk("pullup b off", 16'h0002, {14'h0000, pullup_en});
        rd(`EMSPM_PUR_OFS, 16'h0004, "pullup rb");
        wr(`EMSPM_PUR_OFS, 16'h0002);
        chk("pullup i off", 16'h0001, {14'h0000, pullup_en});
        wr(`EMSPM_PUR_OFS, 16'h0006);
        $display("test pullup done");
    endtask : t_pullup

    task automatic t_master();
        wr(`EMSPM_GPS_OFS, 16'h0006);
        @(posedge clk);
        ms     <= 1'b1;
        mo     <= 1'b1;
        launch <= 1'b1;
        @(posedge clk);
        launch <= 1'b0;
        mo     <= 1'b0;
        #1;
        chk("mosi out", 16'h0001, pin_o[0]);
        chk("mosi oe_n", 16'h0000, oe_n[0]);
        @(posedge clk);
        #1;
        chk("mosi held", 16'h0001, pin_o[0]);
        chk("miso oe_n", 16'h0001, oe_n[1]);
        ext_en[1]  <= 1'b1;
        ext_val[1] <= 1'b0;
        settle();
        chk("miso in low", 16'h0000, mi);
        ext_en[1] <= 1'b0;
        settle();
        chk("miso in high", 16'h0001, mi);
        chk("dec b gated", 16'h0000, dec_b);
        chk("dec i gated", 16'h0000, dec_i);
        $display("test master done");
    endtask : t_master

    task automatic t_slave();
        @(posedge clk);
        ms   <= 1'b0;
        ss_n <= 1'b0;
        @(posedge clk);
        so     <= 1'b1;
        launch <= 1'b1;
        @(posedge clk);
        launch <= 1'b0;
        so     <= 1'b0;
        #1;
        chk("miso drive", 16'h0001, pin_o[1]);
        chk("miso oe_n", 16'h0000, oe_n[1]);
        chk("mosi oe_n", 16'h0001, oe_n[0]);
        ext_en[0]  <= 1'b1;
        ext_val[0] <= 1'b0;
        settle();
        chk("mosi rx", 16'h0000, mo_rx);
        chk("miso kept", 16'h0001, pin_o[1]);
        ext_en[0] <= 1'b0;
        @(posedge clk);
        ss_n <= 1'b1;
        @(posedge clk);
        #1;
        chk("miso float", 16'h0001, oe_n[1]);
        $display("test slave done");
    endtask : t_slave

    task automatic t_timer();
        wr(`EMSPM_GPS_OFS, 16'h0000);
        @(posedge clk);
        t1o <= 1'b1;
        t1e <= 1'b1;
        t2e <= 1'b1;
        @(posedge clk);
        #1;
        chk("tmr oe_n", 16'h0000, {14'h0000, oe_n});
        chk("tmr out", 16'h0001, {14'h0000, pin_o});
        settle();
        chk("tmr2 in", 16'h0000, tm2_in);
        chk("dec i", 16'h0000, dec_i);
        @(posedge clk);
        t1e <= 1'b0;
        t2e <= 1'b0;
        @(posedge clk);
        #1;
        chk("tmr off", 16'h0003, {14'h0000, oe_n});
        $display("test timer done");
    endtask : t_timer

    // gpio drives from its data register; the serial select still wins over it
    task automatic t_gpio();
        wr(`EMSPM_DR_OFS, 16'h0002);
        wr(`EMSPM_DDR_OFS, 16'h0006);
        wr(`EMSPM_PER_OFS, 16'h0006);
        @(posedge clk);
        #1;
        chk("gpio oe_n", 16'h0000, {14'h0000, oe_n});
        chk("gpio out", 16'h0001, {14'h0000, pin_o});
        wr(`EMSPM_DDR_OFS, 16'h0002);
        ext_en[1]  <= 1'b1;
        ext_val[1] <= 1'b0;
        settle();
        rd(`EMSPM_PIN_OFS, 16'h0002, "gpio levels");
        chk("gpio dec b", 16'h0000, dec_b);
        chk("gpio dec i", 16'h0000, dec_i);
        chk("gpio tmr2", 16'h0000, tm2_in);
        wr(`EMSPM_GPS_OFS, 16'h0002);
        @(posedge clk);
        #1;
        chk("ser over gpio", 16'h0001, oe_n[0]);
        wr(`EMSPM_GPS_OFS, 16'h0000);
        wr(`EMSPM_PER_OFS, 16'h0000);
        ext_en[1] <= 1'b0;
        $display("test gpio done");
    endtask : t_gpio

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        close_out();
    end

    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, ext_en, ext_val} = '0;
        {t1o, t1e, t2o, t2e, ms, launch, mo, so} = '0;
        ss_n = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_pullup();
        t_master();
        t_slave();
        t_timer();
        t_gpio();
        close_out();
    end
endmodule : tb_encoder_spi_pin_mux

`default_nettype wire
